// >>> ifd_cfg.svh
// Field positions and encodings shared by the instruction format decoder
// Function
// - Zero-operand words extract no fields
// - Destination field bits 11..8, control source
// - Source field bits 11..8, control destination, jump
// - Two-register direct, indirect, predec, indexed, postinc
// - Multiply-accumulate reads both fields, source post-incremented, destination as accumulator
// - Short displacement base 7..4, disp 3..0
// - Three-field displacement store and load
// - Eight-bit displacement, global base and PC
// - Operand roles follow the operation kind
// - Zero-extend disp, scale by 1, 2, 4
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH
`define IFD_WORD_W 16
`define IFD_HI_FLD_MSB 11
`define IFD_HI_FLD_LSB 8
`define IFD_LO_FLD_MSB 7
`define IFD_LO_FLD_LSB 4
`define IFD_D4_MSB 3
`define IFD_D8_MSB 7
`define IFD_D12_MSB 11
`define IFD_IMM_MSB 7
`define IFD_SCALED_W 10
`define IFD_ZERO_REG 4'h0
`endif

// >>> ifd_pkg.sv
// Types of the instruction format decoder
package ifd_pkg;
  // Operand role variant, chosen upstream from the operation code
  typedef enum logic [4:0] {
    IFD_K_ZERO = 5'b00000, IFD_K_N_DIRECT = 5'b00001,
    IFD_K_N_CTRL = 5'b00010, IFD_K_N_CTRL_PREDEC = 5'b00011,
    IFD_K_M_CTRL = 5'b00100, IFD_K_M_CTRL_POSTINC = 5'b00101,
    IFD_K_M_JUMP = 5'b00110, IFD_K_NM_DIRECT = 5'b00111,
    IFD_K_NM_IND = 5'b01000, IFD_K_NM_PREDEC = 5'b01001,
    IFD_K_NM_INDEXED = 5'b01010, IFD_K_NM_POSTINC = 5'b01011,
    IFD_K_NM_MAC = 5'b01100, IFD_K_MD_LOAD = 5'b01101,
    IFD_K_ND4_STORE = 5'b01110, IFD_K_NMD_STORE = 5'b01111,
    IFD_K_NMD_LOAD = 5'b10000, IFD_K_D_GLB_LOAD = 5'b10001,
    IFD_K_D_GLB_STORE = 5'b10010, IFD_K_D_PC_ADDR = 5'b10011,
    IFD_K_D_BRANCH = 5'b10100, IFD_K_D12_BRANCH = 5'b10101,
    IFD_K_ND8_LOAD = 5'b10110, IFD_K_I_GLB_IDX = 5'b10111,
    IFD_K_I_ZREG = 5'b11000, IFD_K_I_TRAP = 5'b11001,
    IFD_K_NI = 5'b11010
  } ifd_kind_t;

  typedef enum logic [3:0] {
    IFD_AM_NONE = 4'b0000, IFD_AM_DIRECT = 4'b0001,
    IFD_AM_INDIRECT = 4'b0010, IFD_AM_POSTINC = 4'b0011,
    IFD_AM_PREDEC = 4'b0100, IFD_AM_INDEXED = 4'b0101,
    IFD_AM_DISP4 = 4'b0110, IFD_AM_GLB_DISP = 4'b0111,
    IFD_AM_GLB_INDEXED = 4'b1000, IFD_AM_PC_DISP = 4'b1001,
    IFD_AM_PC_REL = 4'b1010, IFD_AM_IMM = 4'b1011,
    IFD_AM_CTRL = 4'b1100, IFD_AM_ACCUM = 4'b1101
  } ifd_mode_t;

  typedef enum logic [1:0] {
    IFD_SZ_BYTE = 2'b00, IFD_SZ_WORD = 2'b01, IFD_SZ_LONG = 2'b10
  } ifd_size_t;

  typedef struct packed {
    logic valid;
    ifd_mode_t src_mode;
    ifd_mode_t dst_mode;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic src_used;
    logic dst_used;
    logic dst_is_src;
    logic [11:0] disp;
    logic [9:0] disp_scaled;
    logic [7:0] imm;
    logic use_zreg;
    logic use_accum;
    logic use_ctrl;
    logic use_glb;
    logic bad_kind;
  } ifd_state_t;
endpackage

// >>> ifd_disp_scale.sv
// Zero-extends and scales a register or base-relative displacement
`timescale 1ns/1ps
`include "ifd_cfg.svh"
module ifd_disp_scale (
  // Displacement in
  input wire logic [7:0] disp_raw,
  input wire logic wide_disp,
  input wire ifd_pkg::ifd_size_t acc_size,
  // Scaled offset out
  output logic [`IFD_SCALED_W-1:0] disp_scaled
);
  import ifd_pkg::*;
  logic [7:0] ext;

  // A 4-bit field never carries sign, so upper bits are forced low
  assign ext = wide_disp ? disp_raw : {4'h0, disp_raw[`IFD_D4_MSB:0]};

  always_comb begin
    unique case (acc_size)
      IFD_SZ_WORD: disp_scaled = {1'b0, ext, 1'b0};
      IFD_SZ_LONG: disp_scaled = {ext, 2'b00};
      default: disp_scaled = {2'b00, ext};
    endcase
  end
endmodule

// >>> ifd_decoder.sv
// Instruction format decoder: fields, addressing modes, implicit operands
`timescale 1ns/1ps
`include "ifd_cfg.svh"
module ifd_decoder (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // From fetch and operation decode
  input wire logic instr_valid,
  input wire logic [`IFD_WORD_W-1:0] instr_word,
  input wire ifd_pkg::ifd_kind_t instr_kind,
  input wire ifd_pkg::ifd_size_t acc_size,
  // Decoded operands
  output logic dec_valid,
  output ifd_pkg::ifd_mode_t src_mode,
  output ifd_pkg::ifd_mode_t dst_mode,
  output logic [3:0] src_reg_field,
  output logic [3:0] dest_reg_field,
  output logic src_reg_used,
  output logic dst_reg_used,
  output logic dst_field_is_src,
  output logic [11:0] disp_field,
  output logic [9:0] disp_scaled,
  output logic [7:0] imm_field,
  // Implicit operands and unassigned-kind flag
  output logic uses_implicit_reg_zero,
  output logic uses_accumulator,
  output logic uses_ctrl_reg,
  output logic uses_global_base_reg,
  output logic bad_kind
);
  import ifd_pkg::*;

  ifd_state_t st_ff;
  ifd_state_t nxt_st;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic [9:0] scaled;
  logic wide_disp;
  default clocking dec_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync_ff);

  function automatic logic [3:0] hi_field(input logic [15:0] w);
    hi_field = w[`IFD_HI_FLD_MSB:`IFD_HI_FLD_LSB];
  endfunction

  function automatic logic [3:0] lo_field(input logic [15:0] w);
    lo_field = w[`IFD_LO_FLD_MSB:`IFD_LO_FLD_LSB];
  endfunction

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Only global-base displacements are 8 bits wide and scaled here
  assign wide_disp = (instr_kind == IFD_K_D_GLB_LOAD) ||
                     (instr_kind == IFD_K_D_GLB_STORE);

  ifd_disp_scale u_scale (
    .disp_raw(instr_word[7:0]),
    .wide_disp(wide_disp),
    .acc_size(acc_size),
    .disp_scaled(scaled)
  );

  always_comb begin
    nxt_st = '0;
    nxt_st.valid = instr_valid;
    nxt_st.src_mode = IFD_AM_NONE;
    nxt_st.dst_mode = IFD_AM_NONE;
    if (instr_valid) begin
      // Same bit position means different roles per kind
      unique case (instr_kind)
        IFD_K_ZERO: begin
          nxt_st.valid = 1'b1;
        end
        IFD_K_N_DIRECT: begin
          nxt_st.dst_reg = hi_field(instr_word);
          nxt_st.dst_used = 1'b1;
          nxt_st.dst_mode = IFD_AM_DIRECT;
        end
        IFD_K_N_CTRL, IFD_K_N_CTRL_PREDEC: begin
          nxt_st.dst_reg = hi_field(instr_word);
          nxt_st.dst_used = 1'b1;
          nxt_st.src_mode = IFD_AM_CTRL;
          nxt_st.use_ctrl = 1'b1;
          nxt_st.dst_mode = (instr_kind == IFD_K_N_CTRL) ?
                            IFD_AM_DIRECT : IFD_AM_PREDEC;
        end
        IFD_K_M_CTRL, IFD_K_M_CTRL_POSTINC, IFD_K_M_JUMP: begin
          nxt_st.src_reg = hi_field(instr_word);
          nxt_st.src_used = 1'b1;
          if (instr_kind == IFD_K_M_JUMP) begin
            nxt_st.src_mode = IFD_AM_INDIRECT;
          end else begin
            nxt_st.dst_mode = IFD_AM_CTRL;
            nxt_st.use_ctrl = 1'b1;
            nxt_st.src_mode = (instr_kind == IFD_K_M_CTRL) ?
                              IFD_AM_DIRECT : IFD_AM_POSTINC;
          end
        end
        IFD_K_NM_DIRECT, IFD_K_NM_IND, IFD_K_NM_PREDEC,
        IFD_K_NM_INDEXED, IFD_K_NM_POSTINC: begin
          nxt_st.dst_reg = hi_field(instr_word);
          nxt_st.src_reg = lo_field(instr_word);
          nxt_st.src_used = 1'b1;
          nxt_st.dst_used = 1'b1;
          nxt_st.src_mode = (instr_kind == IFD_K_NM_POSTINC) ?
                            IFD_AM_POSTINC : IFD_AM_DIRECT;
          unique case (instr_kind)
            IFD_K_NM_IND: nxt_st.dst_mode = IFD_AM_INDIRECT;
            IFD_K_NM_PREDEC: nxt_st.dst_mode = IFD_AM_PREDEC;
            IFD_K_NM_INDEXED: begin
              nxt_st.dst_mode = IFD_AM_INDEXED;
              nxt_st.use_zreg = 1'b1;
            end
            default: nxt_st.dst_mode = IFD_AM_DIRECT;
          endcase
        end
        IFD_K_NM_MAC: begin
          nxt_st.dst_reg = hi_field(instr_word);
          nxt_st.src_reg = lo_field(instr_word);
          nxt_st.src_used = 1'b1;
          nxt_st.dst_used = 1'b1;
          nxt_st.dst_is_src = 1'b1;
          nxt_st.src_mode = IFD_AM_POSTINC;
          nxt_st.dst_mode = IFD_AM_ACCUM;
          nxt_st.use_accum = 1'b1;
        end
        IFD_K_MD_LOAD, IFD_K_ND4_STORE: begin
          nxt_st.disp = {8'h00, instr_word[`IFD_D4_MSB:0]};
          nxt_st.disp_scaled = scaled;
          nxt_st.use_zreg = 1'b1;
          if (instr_kind == IFD_K_MD_LOAD) begin
            nxt_st.src_reg = lo_field(instr_word);
            nxt_st.src_used = 1'b1;
            nxt_st.src_mode = IFD_AM_DISP4;
            nxt_st.dst_mode = IFD_AM_DIRECT;
            nxt_st.dst_reg = `IFD_ZERO_REG;
          end else begin
            nxt_st.dst_reg = lo_field(instr_word);
            nxt_st.dst_used = 1'b1;
            nxt_st.dst_mode = IFD_AM_DISP4;
            nxt_st.src_mode = IFD_AM_DIRECT;
            nxt_st.src_reg = `IFD_ZERO_REG;
          end
        end
        IFD_K_NMD_STORE, IFD_K_NMD_LOAD: begin
          nxt_st.disp = {8'h00, instr_word[`IFD_D4_MSB:0]};
          nxt_st.disp_scaled = scaled;
          nxt_st.dst_reg = hi_field(instr_word);
          nxt_st.src_reg = lo_field(instr_word);
          nxt_st.src_used = 1'b1;
          nxt_st.dst_used = 1'b1;
          if (instr_kind == IFD_K_NMD_STORE) begin
            nxt_st.src_mode = IFD_AM_DIRECT;
            nxt_st.dst_mode = IFD_AM_DISP4;
          end else begin
            nxt_st.src_mode = IFD_AM_DISP4;
            nxt_st.dst_mode = IFD_AM_DIRECT;
          end
        end
        IFD_K_D_GLB_LOAD, IFD_K_D_GLB_STORE: begin
          nxt_st.disp = {4'h0, instr_word[`IFD_D8_MSB:0]};
          nxt_st.disp_scaled = scaled;
          nxt_st.use_zreg = 1'b1;
          nxt_st.use_glb = 1'b1;
          nxt_st.src_mode = (instr_kind == IFD_K_D_GLB_LOAD) ?
                            IFD_AM_GLB_DISP : IFD_AM_DIRECT;
          nxt_st.dst_mode = (instr_kind == IFD_K_D_GLB_LOAD) ?
                            IFD_AM_DIRECT : IFD_AM_GLB_DISP;
        end
        IFD_K_D_PC_ADDR, IFD_K_D_BRANCH: begin
          nxt_st.disp = {4'h0, instr_word[`IFD_D8_MSB:0]};
          if (instr_kind == IFD_K_D_PC_ADDR) begin
            nxt_st.src_mode = IFD_AM_PC_DISP;
            nxt_st.dst_mode = IFD_AM_DIRECT;
            nxt_st.use_zreg = 1'b1;
          end else begin
            nxt_st.src_mode = IFD_AM_PC_REL;
          end
        end
        IFD_K_D12_BRANCH: begin
          nxt_st.disp = instr_word[`IFD_D12_MSB:0];
          nxt_st.src_mode = IFD_AM_PC_REL;
        end
        IFD_K_ND8_LOAD: begin
          nxt_st.disp = {4'h0, instr_word[`IFD_D8_MSB:0]};
          nxt_st.dst_reg = hi_field(instr_word);
          nxt_st.dst_used = 1'b1;
          nxt_st.src_mode = IFD_AM_PC_DISP;
          nxt_st.dst_mode = IFD_AM_DIRECT;
        end
        IFD_K_I_GLB_IDX, IFD_K_I_ZREG, IFD_K_I_TRAP, IFD_K_NI: begin
          nxt_st.imm = instr_word[`IFD_IMM_MSB:0];
          nxt_st.src_mode = IFD_AM_IMM;
          unique case (instr_kind)
            IFD_K_I_GLB_IDX: begin
              nxt_st.dst_mode = IFD_AM_GLB_INDEXED;
              nxt_st.use_zreg = 1'b1;
              nxt_st.use_glb = 1'b1;
            end
            IFD_K_I_ZREG: begin
              nxt_st.dst_mode = IFD_AM_DIRECT;
              nxt_st.use_zreg = 1'b1;
            end
            IFD_K_NI: begin
              nxt_st.dst_reg = hi_field(instr_word);
              nxt_st.dst_used = 1'b1;
              nxt_st.dst_mode = IFD_AM_DIRECT;
            end
            default: nxt_st.dst_mode = IFD_AM_NONE;
          endcase
        end
        default: begin
          // Unassigned kind codes decode to nothing but are flagged
          nxt_st.bad_kind = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dec_valid = st_ff.valid;
  assign src_mode = st_ff.src_mode;
  assign dst_mode = st_ff.dst_mode;
  assign src_reg_field = st_ff.src_reg;
  assign dest_reg_field = st_ff.dst_reg;
  assign src_reg_used = st_ff.src_used;
  assign dst_reg_used = st_ff.dst_used;
  assign dst_field_is_src = st_ff.dst_is_src;
  assign disp_field = st_ff.disp;
  assign disp_scaled = st_ff.disp_scaled;
  assign imm_field = st_ff.imm;
  assign uses_implicit_reg_zero = st_ff.use_zreg;
  assign uses_accumulator = st_ff.use_accum;
  assign uses_ctrl_reg = st_ff.use_ctrl;
  assign uses_global_base_reg = st_ff.use_glb;
  assign bad_kind = st_ff.bad_kind;

  chk_zero_fields: assert property (
    instr_valid && instr_kind == IFD_K_ZERO |=> dec_valid && !src_reg_used
      && !dst_reg_used && disp_field == 12'h000 && imm_field == 8'h00)
    else $error("zero-operand word produced a field");
  chk_ctrl_predec: assert property (
    instr_valid && instr_kind == IFD_K_N_CTRL_PREDEC |=>
      dst_mode == IFD_AM_PREDEC && src_mode == IFD_AM_CTRL
      && dest_reg_field == $past(instr_word[11:8]))
    else $error("control store to predecrement decoded wrongly");
  chk_ctrl_load: assert property (
    instr_valid && instr_kind == IFD_K_M_CTRL_POSTINC |=>
      src_mode == IFD_AM_POSTINC && dst_mode == IFD_AM_CTRL
      && src_reg_field == $past(instr_word[11:8]))
    else $error("control load source decoded wrongly");
  chk_indexed_dst: assert property (
    instr_valid && instr_kind == IFD_K_NM_INDEXED |=>
      dst_mode == IFD_AM_INDEXED && uses_implicit_reg_zero
      && src_reg_field == $past(instr_word[7:4]))
    else $error("indexed destination decoded wrongly");
  chk_mac_sources: assert property (
    instr_valid && instr_kind == IFD_K_NM_MAC |=>
      dst_field_is_src && uses_accumulator && src_mode == IFD_AM_POSTINC)
    else $error("multiply-accumulate operands decoded wrongly");
  chk_disp4_scale: assert property (
    instr_valid && instr_kind == IFD_K_NMD_LOAD && acc_size == IFD_SZ_LONG
      |=> disp_scaled == {4'h0, $past(instr_word[3:0]), 2'b00})
    else $error("four-bit displacement scaled wrongly");
  chk_short_disp: assert property (
    instr_valid && instr_kind == IFD_K_ND4_STORE |=> uses_implicit_reg_zero
      && dest_reg_field == $past(instr_word[7:4])
      && disp_field == {8'h00, $past(instr_word[3:0])})
    else $error("short displacement store decoded wrongly");
  chk_branch_disp: assert property (
    instr_valid && instr_kind == IFD_K_D12_BRANCH |=>
      disp_field == $past(instr_word[11:0]) && src_mode == IFD_AM_PC_REL)
    else $error("twelve-bit branch displacement wrong");
  chk_trap_imm: assert property (
    instr_valid && instr_kind == IFD_K_I_TRAP |=>
      imm_field == $past(instr_word[7:0]) && !dst_reg_used)
    else $error("trap immediate decoded wrongly");
endmodule

// >>> ifd_fetch_model.sv
// Fetch-stage model that presents instruction words to the decoder
`timescale 1ns/1ps
module ifd_fetch_model (
  // Clock
  input wire logic ref_clk,
  // Instruction word towards the decoder
  output logic instr_valid,
  output logic [15:0] instr_word,
  output ifd_pkg::ifd_kind_t instr_kind,
  output ifd_pkg::ifd_size_t acc_size
);
  import ifd_pkg::*;

  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    instr_kind = IFD_K_ZERO;
    acc_size = IFD_SZ_BYTE;
  end

  // Launched just after an edge and held for exactly one cycle
  task automatic present(input logic [15:0] w, input ifd_kind_t k,
                         input ifd_size_t s);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_kind <= k;
    acc_size <= s;
  endtask

  // Idle bus shows the inverted word so a stale value cannot match
  task automatic idle();
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    instr_word <= ~instr_word;
  endtask
endmodule

// >>> ifd_decoder_tb_top.sv
// Self-checking testbench for the instruction format decoder
`timescale 1ns/1ps
module ifd_decoder_tb_top;
  import ifd_pkg::*;

  logic ref_clk;
  logic rstn;
  logic instr_valid;
  logic [15:0] instr_word;
  ifd_kind_t instr_kind;
  ifd_size_t acc_size;
  logic dec_valid;
  ifd_mode_t src_mode;
  ifd_mode_t dst_mode;
  logic [3:0] src_reg_field;
  logic [3:0] dest_reg_field;
  logic src_reg_used;
  logic dst_reg_used;
  logic dst_field_is_src;
  logic [11:0] disp_field;
  logic [9:0] disp_scaled;
  logic [7:0] imm_field;
  logic uses_implicit_reg_zero;
  logic uses_accumulator;
  logic uses_ctrl_reg;
  logic uses_global_base_reg;
  logic bad_kind;
  int mismatches;
  int num_checks;
  logic [15:0] cur_w;
  ifd_size_t cur_sz;
  ifd_state_t exp_q;
  logic exp_live;

  ifd_fetch_model u_fetch (
    .ref_clk(ref_clk), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_kind(instr_kind), .acc_size(acc_size)
  );

  ifd_decoder dut (
    .ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_kind(instr_kind), .acc_size(acc_size),
    .dec_valid(dec_valid), .src_mode(src_mode), .dst_mode(dst_mode),
    .src_reg_field(src_reg_field), .dest_reg_field(dest_reg_field),
    .src_reg_used(src_reg_used), .dst_reg_used(dst_reg_used),
    .dst_field_is_src(dst_field_is_src), .disp_field(disp_field),
    .disp_scaled(disp_scaled), .imm_field(imm_field),
    .uses_implicit_reg_zero(uses_implicit_reg_zero),
    .uses_accumulator(uses_accumulator), .uses_ctrl_reg(uses_ctrl_reg),
    .uses_global_base_reg(uses_global_base_reg), .bad_kind(bad_kind)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input string name, input logic [11:0] e,
                     input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_out(input ifd_state_t e);
    cmp("dec_valid", 12'(e.valid), 12'(dec_valid));
    cmp("src_mode", 12'(e.src_mode), 12'(src_mode));
    cmp("dst_mode", 12'(e.dst_mode), 12'(dst_mode));
    cmp("src_reg_field", 12'(e.src_reg), 12'(src_reg_field));
    cmp("dest_reg_field", 12'(e.dst_reg), 12'(dest_reg_field));
    cmp("src_reg_used", 12'(e.src_used), 12'(src_reg_used));
    cmp("dst_reg_used", 12'(e.dst_used), 12'(dst_reg_used));
    cmp("dst_field_is_src", 12'(e.dst_is_src), 12'(dst_field_is_src));
    cmp("disp_field", e.disp, disp_field);
    cmp("disp_scaled", 12'(e.disp_scaled), 12'(disp_scaled));
    cmp("imm_field", 12'(e.imm), 12'(imm_field));
    cmp("uses_zero_reg", 12'(e.use_zreg), 12'(uses_implicit_reg_zero));
    cmp("uses_accum", 12'(e.use_accum), 12'(uses_accumulator));
    cmp("uses_ctrl", 12'(e.use_ctrl), 12'(uses_ctrl_reg));
    cmp("uses_glb", 12'(e.use_glb), 12'(uses_global_base_reg));
    cmp("bad_kind", 12'(e.bad_kind), 12'(bad_kind));
  endtask

  function automatic logic [3:0] fld(input int s);
    return s == 1 ? cur_w[11:8] : (s == 2 ? cur_w[7:4] : 4'h0);
  endfunction

  // Selectors: 1 high nibble, 2 low nibble; disp 1 four-bit scaled,
  // 2 eight-bit raw, 3 twelve-bit, 4 eight-bit scaled
  task automatic run(input ifd_kind_t k, input ifd_mode_t sm,
                     input ifd_mode_t dm, input int ss, input int ds,
                     input int dsel, input logic [3:0] fl);
    ifd_state_t e;
    logic [11:0] d;
    e = '0;
    d = 12'h000;
    if (dsel == 1) d = {8'h00, cur_w[3:0]};
    if (dsel == 2 || dsel == 4) d = {4'h0, cur_w[7:0]};
    if (dsel == 3) d = cur_w[11:0];
    e.valid = 1'b1;
    e.src_mode = sm;
    e.dst_mode = dm;
    e.src_reg = fld(ss);
    e.dst_reg = fld(ds);
    e.src_used = (ss != 0);
    e.dst_used = (ds != 0);
    e.dst_is_src = (k == IFD_K_NM_MAC);
    e.disp = d;
    if (dsel == 1 || dsel == 4) e.disp_scaled = d[9:0] << cur_sz;
    if (sm == IFD_AM_IMM) e.imm = cur_w[7:0];
    {e.use_zreg, e.use_accum, e.use_ctrl, e.use_glb} = fl;
    e.bad_kind = (5'(k) > 5'd26);
    u_fetch.present(cur_w, k, cur_sz);
    #1;
    if (exp_live) check_out(exp_q);
    exp_q = e;
    exp_live = 1'b1;
  endtask

  // Last result must stand for one cycle only
  task automatic flush();
    u_fetch.idle();
    #1;
    if (exp_live) check_out(exp_q);
    exp_live = 1'b0;
    u_fetch.idle();
    #1;
    cmp("dec_valid_idle", 12'h000, 12'(dec_valid));
    check_out('0);
  endtask

  task automatic test_sweep();
    cur_w = 16'h9a3c;
    cur_sz = IFD_SZ_LONG;
    run(IFD_K_ZERO, IFD_AM_NONE, IFD_AM_NONE, 0, 0, 0, 4'h0);
    run(IFD_K_N_DIRECT, IFD_AM_NONE, IFD_AM_DIRECT, 0, 1, 0, 4'h0);
    run(IFD_K_N_CTRL, IFD_AM_CTRL, IFD_AM_DIRECT, 0, 1, 0, 4'h2);
    run(IFD_K_N_CTRL_PREDEC, IFD_AM_CTRL, IFD_AM_PREDEC, 0,1,0,4'h2);
    run(IFD_K_M_CTRL, IFD_AM_DIRECT, IFD_AM_CTRL, 1, 0, 0, 4'h2);
    run(IFD_K_M_CTRL_POSTINC, IFD_AM_POSTINC, IFD_AM_CTRL,1,0,0,4'h2);
    run(IFD_K_M_JUMP, IFD_AM_INDIRECT, IFD_AM_NONE, 1, 0, 0, 4'h0);
    run(IFD_K_NM_DIRECT, IFD_AM_DIRECT, IFD_AM_DIRECT, 2, 1, 0, 4'h0);
    run(IFD_K_NM_IND, IFD_AM_DIRECT, IFD_AM_INDIRECT, 2, 1, 0, 4'h0);
    run(IFD_K_NM_PREDEC, IFD_AM_DIRECT, IFD_AM_PREDEC, 2, 1, 0, 4'h0);
    run(IFD_K_NM_INDEXED, IFD_AM_DIRECT, IFD_AM_INDEXED, 2,1,0,4'h8);
    run(IFD_K_NM_POSTINC, IFD_AM_POSTINC, IFD_AM_DIRECT, 2,1,0,4'h0);
    run(IFD_K_NM_MAC, IFD_AM_POSTINC, IFD_AM_ACCUM, 2, 1, 0, 4'h4);
    run(IFD_K_MD_LOAD, IFD_AM_DISP4, IFD_AM_DIRECT, 2, 0, 1, 4'h8);
    run(IFD_K_ND4_STORE, IFD_AM_DIRECT, IFD_AM_DISP4, 0, 2, 1, 4'h8);
    run(IFD_K_NMD_STORE, IFD_AM_DIRECT, IFD_AM_DISP4, 2, 1, 1, 4'h0);
    run(IFD_K_NMD_LOAD, IFD_AM_DISP4, IFD_AM_DIRECT, 2, 1, 1, 4'h0);
    run(IFD_K_D_GLB_LOAD, IFD_AM_GLB_DISP, IFD_AM_DIRECT,0,0,4,4'h9);
    run(IFD_K_D_GLB_STORE, IFD_AM_DIRECT, IFD_AM_GLB_DISP,0,0,4,4'h9);
    run(IFD_K_D_PC_ADDR, IFD_AM_PC_DISP, IFD_AM_DIRECT, 0,0,2,4'h8);
    run(IFD_K_D_BRANCH, IFD_AM_PC_REL, IFD_AM_NONE, 0, 0, 2, 4'h0);
    run(IFD_K_D12_BRANCH, IFD_AM_PC_REL, IFD_AM_NONE, 0, 0, 3, 4'h0);
    run(IFD_K_ND8_LOAD, IFD_AM_PC_DISP, IFD_AM_DIRECT, 0,1,2,4'h0);
    run(IFD_K_I_GLB_IDX, IFD_AM_IMM, IFD_AM_GLB_INDEXED,0,0,0,4'h9);
    run(IFD_K_I_ZREG, IFD_AM_IMM, IFD_AM_DIRECT, 0, 0, 0, 4'h8);
    run(IFD_K_I_TRAP, IFD_AM_IMM, IFD_AM_NONE, 0, 0, 0, 4'h0);
    run(IFD_K_NI, IFD_AM_IMM, IFD_AM_DIRECT, 0, 1, 0, 4'h0);
    flush();
    $display("test_sweep done");
  endtask

  task automatic test_scale();
    for (int s = 0; s < 3; s++) begin
      cur_sz = ifd_size_t'(s);
      cur_w = 16'h12af;
      run(IFD_K_NMD_LOAD, IFD_AM_DISP4, IFD_AM_DIRECT, 2, 1, 1, 4'h0);
      cur_w = 16'h00ff;
      run(IFD_K_D_GLB_LOAD, IFD_AM_GLB_DISP, IFD_AM_DIRECT,0,0,4,4'h9);
    end
    flush();
    $display("test_scale done");
  endtask

  task automatic test_bad_kind();
    cur_w = 16'hffff;
    cur_sz = IFD_SZ_WORD;
    run(ifd_kind_t'(5'h1f), IFD_AM_NONE, IFD_AM_NONE, 0, 0, 0, 4'h0);
    run(IFD_K_NI, IFD_AM_IMM, IFD_AM_DIRECT, 0, 1, 0, 4'h0);
    flush();
    $display("test_bad_kind done");
  endtask

  task automatic test_midreset();
    cur_w = 16'h4567;
    u_fetch.present(cur_w, IFD_K_NM_DIRECT, IFD_SZ_BYTE);
    u_fetch.idle();
    rstn <= 1'b0;
    #1;
    // A synchronous clear would still show this edge's result
    cmp("dec_valid_rst", 12'h000, 12'(dec_valid));
    cmp("dest_reg_rst", 12'h000, 12'(dest_reg_field));
    @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp("dec_valid_rel", 12'h000, 12'(dec_valid));
    run(IFD_K_NM_DIRECT, IFD_AM_DIRECT, IFD_AM_DIRECT, 2, 1, 0, 4'h0);
    flush();
    $display("test_midreset done");
  endtask

  initial begin
    rstn = 1'b0;
    mismatches = 0;
    num_checks = 0;
    exp_live = 1'b0;
    cur_w = 16'h0000;
    cur_sz = IFD_SZ_BYTE;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_sweep();
    test_scale();
    test_bad_kind();
    test_midreset();
    finish_test();
  end

  // About 60 cycles of work; the limit leaves a wide margin
  initial begin
    #20000;
    mismatches++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
